// ===== rtl/scm_pkg.sv
package scm_pkg;
    // ----------------------------------------
    // register map (byte addresses on apb)
    // ----------------------------------------
    localparam logic [7:0] SCM_ADDR_SYSCLK = 8'h00;
    localparam logic [7:0] SCM_ADDR_FRC = 8'h04;
    localparam logic [7:0] SCM_ADDR_FXT = 8'h08;
    localparam logic [7:0] SCM_ADDR_WXT = 8'h0c;
    localparam logic [7:0] SCM_ADDR_MODE = 8'h10;
    localparam logic [7:0] SCM_ADDR_IRQ_STAT = 8'h14;
    localparam logic [7:0] SCM_ADDR_IRQ_MASK = 8'h18;
    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int SCM_DIVSEL_LSB = 5;
    localparam int SCM_HSS_BIT = 3;
    localparam int SCM_LSS_BIT = 2;
    localparam int SCM_HKEEP_BIT = 1;
    localparam int SCM_LKEEP_BIT = 0;
    localparam int SCM_EN_BIT = 0;
    localparam int SCM_FLAG_BIT = 1;
    localparam int SCM_MODE_BIT = 2;
    localparam int SCM_FSEL_LSB = 2;
    // ----------------------------------------
    // reset values and the divider select code of the subsidiary clock
    // ----------------------------------------
    localparam logic [7:0] SCM_SYSCLK_RST = 8'h00;
    localparam logic [1:0] SCM_FSEL_RST = 2'h0;
    localparam logic SCM_FRC_EN_RST = 1'b1;
    localparam logic [2:0] SCM_DIVSEL_SUB = 3'h7;
    // ----------------------------------------
    // oscillator start-up times, ns
    // ----------------------------------------
    localparam int SCM_CLK_NS = 8;
    localparam int SCM_FRC_START_NS = 800;
    localparam int SCM_FXT_START_NS = 1600;
    localparam int SCM_WXT_START_NS = 3200;
    localparam int SCM_FRC_CYC = (SCM_FRC_START_NS + SCM_CLK_NS - 1) / SCM_CLK_NS;
    localparam int SCM_FXT_CYC = (SCM_FXT_START_NS + SCM_CLK_NS - 1) / SCM_CLK_NS;
    localparam int SCM_WXT_CYC = (SCM_WXT_START_NS + SCM_CLK_NS - 1) / SCM_CLK_NS;
    localparam int SCM_CNT_W = 10;
    // ----------------------------------------
    // operating modes, gray along the listed order
    // ----------------------------------------
    typedef enum logic [2:0] {
        SCM_FAST = 3'h0,
        SCM_SLOW = 3'h1,
        SCM_IDLE_LOW_ONLY = 3'h3,
        SCM_IDLE_BOTH_CLOCKS = 3'h2,
        SCM_IDLE_HIGH_ONLY = 3'h6,
        SCM_SLEEP = 3'h4
    } scm_mode_e;
endpackage : scm_pkg

// ===== rtl/scm_system_clock_mode_control.sv
`timescale 1ns/1ps
`default_nettype none
module scm_system_clock_mode_control
    import scm_pkg::*;
#(
    parameter int DIV_W = 6
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic halt_i,
    input wire logic wake_i,
    input wire logic watchdog_timer_en_i,
    output logic cpu_clk_en_o,
    output logic sysclk_en_o,
    output logic high_speed_clock_en_o,
    output logic [DIV_W:0] high_div_tick_o,
    output logic subsidiary_clock_en_o,
    output logic internal_slow_rc_en_o,
    output logic internal_fast_rc_en_o,
    output logic external_fast_crystal_en_o,
    output logic external_watch_crystal_en_o,
    output logic sysclk_from_sub_o,
    output logic [2:0] mode_o,
    output logic irq_o
);
    import scm_pkg::*;

    // ----------------------------------------
    // control registers
    // ----------------------------------------
    logic [2:0] sysclk_div_select;
    logic high_source_select;
    logic low_source_select;
    logic high_osc_idle_keep;
    logic low_osc_idle_keep;
    logic [1:0] fast_rc_freq_select;
    logic fast_rc_enable;
    logic fast_rc_stable_flag;
    logic fast_crystal_mode;
    logic fast_crystal_enable;
    logic fast_crystal_stable_flag;
    logic watch_crystal_speedup;
    logic watch_crystal_enable;
    logic watch_crystal_stable_flag;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic [SCM_CNT_W-1:0] frc_cnt;
    logic [SCM_CNT_W-1:0] fxt_cnt;
    logic [SCM_CNT_W-1:0] wxt_cnt;
    logic [DIV_W-1:0] div_cnt;
    scm_mode_e mode;

    function automatic logic [SCM_CNT_W-1:0] start_count(input int cyc);
        start_count = SCM_CNT_W'(cyc);
    endfunction : start_count

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    wire logic acc = psel_i & penable_i;
    wire logic wr = acc & pwrite_i;
    wire logic wr_sys = wr & (paddr_i == SCM_ADDR_SYSCLK);
    wire logic wr_frc = wr & (paddr_i == SCM_ADDR_FRC);
    wire logic wr_fxt = wr & (paddr_i == SCM_ADDR_FXT);
    wire logic wr_wxt = wr & (paddr_i == SCM_ADDR_WXT);
    wire logic wr_stat = wr & (paddr_i == SCM_ADDR_IRQ_STAT);
    wire logic wr_mask = wr & (paddr_i == SCM_ADDR_IRQ_MASK);
    wire logic mapped = (paddr_i == SCM_ADDR_SYSCLK) | (paddr_i == SCM_ADDR_FRC)
        | (paddr_i == SCM_ADDR_FXT) | (paddr_i == SCM_ADDR_WXT)
        | (paddr_i == SCM_ADDR_MODE) | (paddr_i == SCM_ADDR_IRQ_STAT)
        | (paddr_i == SCM_ADDR_IRQ_MASK);
    wire logic [7:0] sys_val = {sysclk_div_select, 1'b0, high_source_select,
        low_source_select, high_osc_idle_keep, low_osc_idle_keep};
    wire logic [7:0] frc_val = {4'h0, fast_rc_freq_select, fast_rc_stable_flag,
        fast_rc_enable};
    wire logic [7:0] fxt_val = {5'h00, fast_crystal_mode, fast_crystal_stable_flag,
        fast_crystal_enable};
    wire logic [7:0] wxt_val = {5'h00, watch_crystal_speedup, watch_crystal_stable_flag,
        watch_crystal_enable};
    wire logic [7:0] rd_val =
        (paddr_i == SCM_ADDR_SYSCLK) ? sys_val :
        (paddr_i == SCM_ADDR_FRC) ? frc_val :
        (paddr_i == SCM_ADDR_FXT) ? fxt_val :
        (paddr_i == SCM_ADDR_WXT) ? wxt_val :
        (paddr_i == SCM_ADDR_MODE) ? {5'h00, mode} :
        (paddr_i == SCM_ADDR_IRQ_STAT) ? {5'h00, irq_stat} :
        (paddr_i == SCM_ADDR_IRQ_MASK) ? {5'h00, irq_mask} : 8'h00;

    // ----------------------------------------
    // clock selection
    // ----------------------------------------
    wire logic running = (mode == SCM_FAST) | (mode == SCM_SLOW);
    wire logic sub_sel = (sysclk_div_select == SCM_DIVSEL_SUB);
    wire logic high_ok = high_source_select ? fast_crystal_stable_flag
        : fast_rc_stable_flag;
    wire logic low_ok = low_source_select ? watch_crystal_stable_flag : 1'b1;
    wire logic wxt_is_sys = sub_sel & low_source_select;
    wire logic frc_chg = wr_frc & ((pwdata_i[SCM_EN_BIT] & ~fast_rc_enable)
        | (pwdata_i[SCM_FSEL_LSB +: 2] != fast_rc_freq_select));
    wire logic [2:0] events = {
        ~watch_crystal_stable_flag & (wxt_cnt == start_count(1)) & watch_crystal_enable,
        ~fast_crystal_stable_flag & (fxt_cnt == start_count(1)) & fast_crystal_enable,
        ~fast_rc_stable_flag & (frc_cnt == start_count(1)) & fast_rc_enable & ~frc_chg};
    // halted mode decoded from keep bits sampled at the halt
    wire scm_mode_e halt_mode =
        (high_osc_idle_keep & low_osc_idle_keep) ? SCM_IDLE_BOTH_CLOCKS :
        high_osc_idle_keep ? SCM_IDLE_HIGH_ONLY :
        low_osc_idle_keep ? SCM_IDLE_LOW_ONLY : SCM_SLEEP;
    // high clock on in run (slow mode follows the enable bits), idle_both_clocks and idle_high_only
    wire logic next_high_on = (mode == SCM_FAST) | (mode == SCM_IDLE_BOTH_CLOCKS)
        | (mode == SCM_IDLE_HIGH_ONLY)
        | ((mode == SCM_SLOW) & (high_source_select ? fast_crystal_enable
        : fast_rc_enable));
    wire logic next_sub_on = running | (mode == SCM_IDLE_LOW_ONLY)
        | (mode == SCM_IDLE_BOTH_CLOCKS);
    wire logic next_sys_on = running | (mode == SCM_IDLE_BOTH_CLOCKS)
        | ((mode == SCM_IDLE_LOW_ONLY) & sub_sel)
        | ((mode == SCM_IDLE_HIGH_ONLY) & ~sub_sel);
    wire logic next_slow_rc_on = (mode != SCM_SLEEP) | watchdog_timer_en_i;
    wire logic [DIV_W:0] next_ticks;
    for (genvar g = 0; g <= DIV_W; g++) begin : g_tick
        if (g == 0) begin : g_one
            assign next_ticks[g] = next_high_on;
        end else begin : g_div
            assign next_ticks[g] = next_high_on & (div_cnt[g-1:0] == '1);
        end
    end

    // ----------------------------------------
    // mode state machine
    // ----------------------------------------
    scm_mode_e next_mode;
    always_comb begin
        next_mode = mode;
        case (mode)
            SCM_FAST, SCM_SLOW: begin
                if (halt_i) begin
                    next_mode = halt_mode;
                end else if (sub_sel & low_ok) begin
                    next_mode = SCM_SLOW;
                end else if (~sub_sel & high_ok) begin
                    next_mode = SCM_FAST;
                end
            end
            SCM_IDLE_LOW_ONLY, SCM_IDLE_BOTH_CLOCKS, SCM_IDLE_HIGH_ONLY, SCM_SLEEP: begin
                if (wake_i) begin
                    next_mode = sub_sel ? SCM_SLOW : SCM_FAST;
                end
            end
            default: next_mode = SCM_FAST;
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            mode <= SCM_FAST;
            div_cnt <= '0;
        end else begin
            mode <= next_mode;
            div_cnt <= div_cnt + DIV_W'(1);
        end
    end

    // ----------------------------------------
    // registers and stable flags
    // ----------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            {sysclk_div_select, high_source_select, low_source_select} <= '0;
            {high_osc_idle_keep, low_osc_idle_keep} <= '0;
            fast_rc_freq_select <= SCM_FSEL_RST;
            fast_rc_enable <= SCM_FRC_EN_RST;
            fast_rc_stable_flag <= 1'b0;
            frc_cnt <= start_count(SCM_FRC_CYC);
            {fast_crystal_mode, fast_crystal_enable, fast_crystal_stable_flag} <= '0;
            {watch_crystal_speedup, watch_crystal_enable, watch_crystal_stable_flag} <= '0;
            fxt_cnt <= start_count(SCM_FXT_CYC);
            wxt_cnt <= start_count(SCM_WXT_CYC);
            irq_stat <= '0;
            irq_mask <= '0;
        end else begin
            if (wr_sys) begin
                sysclk_div_select <= pwdata_i[SCM_DIVSEL_LSB +: 3];
                high_source_select <= pwdata_i[SCM_HSS_BIT];
                low_source_select <= pwdata_i[SCM_LSS_BIT];
                high_osc_idle_keep <= pwdata_i[SCM_HKEEP_BIT];
                low_osc_idle_keep <= pwdata_i[SCM_LKEEP_BIT];
            end
            if (wr_frc) begin
                fast_rc_enable <= pwdata_i[SCM_EN_BIT];
                fast_rc_freq_select <= pwdata_i[SCM_FSEL_LSB +: 2];
            end
            if (frc_chg | ~fast_rc_enable) begin
                fast_rc_stable_flag <= 1'b0;
                frc_cnt <= start_count(SCM_FRC_CYC);
            end else if (frc_cnt > start_count(1)) begin
                frc_cnt <= frc_cnt - start_count(1);
            end else begin
                fast_rc_stable_flag <= 1'b1;
            end
            if (wr_fxt) begin
                fast_crystal_enable <= pwdata_i[SCM_EN_BIT];
                fast_crystal_mode <= pwdata_i[SCM_MODE_BIT];
            end
            if (~fast_crystal_enable) begin
                fast_crystal_stable_flag <= 1'b0;
                fxt_cnt <= start_count(SCM_FXT_CYC);
            end else if (fxt_cnt > start_count(1)) begin
                fxt_cnt <= fxt_cnt - start_count(1);
            end else begin
                fast_crystal_stable_flag <= 1'b1;
            end
            if (wr_wxt) begin
                watch_crystal_enable <= pwdata_i[SCM_EN_BIT];
                if (~wxt_is_sys) begin
                    watch_crystal_speedup <= pwdata_i[SCM_MODE_BIT];
                end
            end
            if (~watch_crystal_enable) begin
                watch_crystal_stable_flag <= 1'b0;
                wxt_cnt <= start_count(SCM_WXT_CYC);
            end else if (wxt_cnt > start_count(1)) begin
                wxt_cnt <= wxt_cnt - start_count(1);
            end else begin
                watch_crystal_stable_flag <= 1'b1;
            end
            // set wins over write-one-to-clear
            irq_stat <= (irq_stat & ~(wr_stat ? pwdata_i[2:0] : 3'h0)) | events;
            if (wr_mask) begin
                irq_mask <= pwdata_i[2:0];
            end
        end
    end

    // ----------------------------------------
    // registered outputs
    // ----------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            prdata_o <= '0;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            cpu_clk_en_o <= 1'b0;
            sysclk_en_o <= 1'b0;
            high_speed_clock_en_o <= 1'b0;
            high_div_tick_o <= '0;
            subsidiary_clock_en_o <= 1'b0;
            internal_slow_rc_en_o <= 1'b0;
            internal_fast_rc_en_o <= 1'b0;
            external_fast_crystal_en_o <= 1'b0;
            external_watch_crystal_en_o <= 1'b0;
            sysclk_from_sub_o <= 1'b0;
            mode_o <= SCM_FAST;
            irq_o <= 1'b0;
        end else begin
            pready_o <= psel_i & ~penable_i;
            pslverr_o <= psel_i & ~penable_i & ~mapped;
            prdata_o <= (psel_i & ~penable_i & ~pwrite_i) ? {24'h000000, rd_val} : '0;
            cpu_clk_en_o <= running;
            sysclk_en_o <= next_sys_on;
            high_speed_clock_en_o <= next_high_on;
            high_div_tick_o <= next_ticks;
            subsidiary_clock_en_o <= next_sub_on;
            internal_slow_rc_en_o <= next_slow_rc_on;
            internal_fast_rc_en_o <= fast_rc_enable & next_high_on & ~high_source_select;
            external_fast_crystal_en_o <= fast_crystal_enable & next_high_on
                & high_source_select;
            external_watch_crystal_en_o <= watch_crystal_enable & next_sub_on;
            sysclk_from_sub_o <= sub_sel;
            mode_o <= mode;
            irq_o <= |(((irq_stat & ~(wr_stat ? pwdata_i[2:0] : 3'h0)) | events) & ~irq_mask);
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_sleep_all_off: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (mode == SCM_SLEEP) |=> !sysclk_en_o && !high_speed_clock_en_o && !subsidiary_clock_en_o)
        else $error("clocks running in sleep");
    a_sleep_slow_rc: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (mode == SCM_SLEEP) |=> internal_slow_rc_en_o == $past(watchdog_timer_en_i))
        else $error("slow rc not following watchdog in sleep");
    a_idle_low_sys: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (mode == SCM_IDLE_LOW_ONLY) |=> subsidiary_clock_en_o && !high_speed_clock_en_o
        && sysclk_en_o == $past(sub_sel))
        else $error("idle low only clocks wrong");
    a_idle_both_on: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (mode == SCM_IDLE_BOTH_CLOCKS) |=> sysclk_en_o && high_speed_clock_en_o
        && subsidiary_clock_en_o && !cpu_clk_en_o)
        else $error("idle both clocks wrong");
    a_idle_high_sys: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (mode == SCM_IDLE_HIGH_ONLY) |=> high_speed_clock_en_o && !subsidiary_clock_en_o
        && sysclk_en_o == !$past(sub_sel))
        else $error("idle high only clocks wrong");
    a_halt_only: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (running && !halt_i) |=> (mode == SCM_FAST || mode == SCM_SLOW))
        else $error("halted mode without halt");
    a_halt_decode: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (running && halt_i && !high_osc_idle_keep && !low_osc_idle_keep) |=> mode == SCM_SLEEP)
        else $error("halt with no keep bits did not sleep");
    a_frc_flag_clr: assert property (@(posedge core_clk_i) disable iff (rst_i)
        frc_chg |=> !fast_rc_stable_flag ##0 (!fast_rc_stable_flag)[*2])
        else $error("fast rc flag not cleared");
    a_wxt_mode_lock: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (wr_wxt && wxt_is_sys) |=> $stable(watch_crystal_speedup))
        else $error("watch crystal mode changed while selected");
    a_slow_rc_run: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (mode != SCM_SLEEP) |=> internal_slow_rc_en_o)
        else $error("slow rc off outside sleep");
endmodule : scm_system_clock_mode_control
`default_nettype wire

// ===== verif/scm_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// cpu core stand-in: issues halt and wake
// ----------------------------------------
module scm_cpu_model (
    input wire logic clk_i,
    input wire logic cpu_clk_en_i,
    output logic halt_o,
    output logic wake_o
);
    initial begin
        halt_o = 1'b0;
        wake_o = 1'b0;
    end
    // a real core only executes halt while clocked; forced covers a stray pulse
    task automatic do_halt(input bit forced);
        int n;
        n = 0;
        @(posedge clk_i);
        while (!forced && cpu_clk_en_i !== 1'b1 && n < 100) begin
            @(posedge clk_i);
            n++;
        end
        halt_o <= 1'b1;
        @(posedge clk_i);
        halt_o <= 1'b0;
    endtask : do_halt
    task automatic do_wake();
        @(posedge clk_i);
        wake_o <= 1'b1;
        @(posedge clk_i);
        wake_o <= 1'b0;
    endtask : do_wake
endmodule : scm_cpu_model
`default_nettype wire

// ===== verif/test_system_clock_mode_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_system_clock_mode_control;
    import scm_pkg::*;
    // en holds {cpu, sysclk, high, sub, slow rc}
    typedef struct packed {logic [7:0] ctl; logic wd; logic [2:0] mode; logic [4:0] en;} scm_row_s;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, wd = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, halt, wake, e, irq, from_sub;
    logic cpu_en, sys_en, high_en, sub_en, slow_rc_en, frc_en, fxt_en, wxt_en;
    logic [6:0] tick;
    logic [2:0] mode;
    int bad_count = 0, cmp_count = 0;
    int tc[7];
    scm_row_s rows[9] = '{
        '{8'h00, 1'b0, 3'h4, 5'b00000}, '{8'h00, 1'b1, 3'h4, 5'b00001},
        '{8'he0, 1'b0, 3'h4, 5'b00000}, '{8'h01, 1'b0, 3'h3, 5'b00011},
        '{8'he1, 1'b0, 3'h3, 5'b01011}, '{8'h03, 1'b0, 3'h2, 5'b01111},
        '{8'he3, 1'b0, 3'h2, 5'b01111}, '{8'h02, 1'b0, 3'h6, 5'b01101},
        '{8'he2, 1'b0, 3'h6, 5'b00101}};
    always #4 clk = ~clk;
    scm_system_clock_mode_control scm_system_clock_mode_control_inst (
        .core_clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .halt_i(halt), .wake_i(wake),
        .watchdog_timer_en_i(wd), .cpu_clk_en_o(cpu_en), .sysclk_en_o(sys_en),
        .high_speed_clock_en_o(high_en), .high_div_tick_o(tick),
        .subsidiary_clock_en_o(sub_en), .internal_slow_rc_en_o(slow_rc_en),
        .internal_fast_rc_en_o(frc_en), .external_fast_crystal_en_o(fxt_en),
        .external_watch_crystal_en_o(wxt_en), .sysclk_from_sub_o(from_sub),
        .mode_o(mode), .irq_o(irq));
    scm_cpu_model scm_cpu_model_inst (
        .clk_i(clk), .cpu_clk_en_i(cpu_en), .halt_o(halt), .wake_o(wake));
    task automatic conclude();
        $display("checks %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : conclude
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // the slave decides its own wait; the bound only guards against a hang
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) chk("pready", 32'h1, 32'h0);
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, exp, q);
    endtask : rd
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask : wt
    initial begin
        wt(20000);
        chk("timeout", 32'h0, 32'h1);
        conclude();
    end
    initial begin
        wt(5);
        rst <= 1'b0;
        wt(120);
        // ----------------------------------------
        // halt into every mode from every select class
        // ----------------------------------------
        foreach (rows[i]) begin
            wd <= rows[i].wd;
            apb(1'b1, SCM_ADDR_SYSCLK, {24'h0, rows[i].ctl});
            wt(10);
            chk("run mode", {31'h0, rows[i].ctl[7:5] == 3'h7}, 32'(mode));
            scm_cpu_model_inst.do_halt(1'b0);
            wt(5);
            chk("halt mode", 32'(rows[i].mode), 32'(mode));
            chk("enables", 32'(rows[i].en), 32'({cpu_en, sys_en, high_en, sub_en, slow_rc_en}));
            scm_cpu_model_inst.do_halt(1'b1);
            wt(5);
            chk("rehalt", 32'(rows[i].mode), 32'(mode));
            scm_cpu_model_inst.do_wake();
            wt(8);
            chk("woken", {31'h0, rows[i].ctl[7:5] == 3'h7}, 32'(mode));
            $display("row %0d done", i);
        end
        // ----------------------------------------
        // register map, read-only and unmapped places
        // ----------------------------------------
        apb(1'b1, SCM_ADDR_SYSCLK, 32'h17);
        rd(SCM_ADDR_SYSCLK, 32'h07, "sysclk");
        apb(1'b1, SCM_ADDR_SYSCLK, 32'h0);
        apb(1'b1, SCM_ADDR_MODE, 32'h6);
        rd(SCM_ADDR_MODE, 32'h0, "mode reg");
        rd(8'h1c, 32'h0, "unmapped");
        chk("slverr", 32'h1, 32'(e));
        apb(1'b1, SCM_ADDR_FRC, 32'h07);
        rd(SCM_ADDR_FRC, 32'h05, "frc restart");
        wt(110);
        rd(SCM_ADDR_FRC, 32'h07, "frc stable");
        // mask bit set means the source is kept off the line
        chk("irq", 32'h1, 32'(irq));
        apb(1'b1, SCM_ADDR_IRQ_MASK, 32'h1);
        wt(3);
        chk("irq masked", 32'h0, 32'(irq));
        apb(1'b1, SCM_ADDR_IRQ_MASK, 32'h0);
        apb(1'b1, SCM_ADDR_IRQ_STAT, 32'h1);
        rd(SCM_ADDR_IRQ_STAT, 32'h0, "w1c");
        chk("irq clr", 32'h0, 32'(irq));
        $display("register test done");
        // ----------------------------------------
        // fast crystal, slow mode, dividers
        // ----------------------------------------
        apb(1'b1, SCM_ADDR_FXT, 32'h1);
        wt(210);
        rd(SCM_ADDR_FXT, 32'h3, "fxt stable");
        apb(1'b1, SCM_ADDR_SYSCLK, 32'h08);
        wt(10);
        chk("fxt on", 32'h3, 32'({frc_en, fxt_en, high_en}));
        apb(1'b1, SCM_ADDR_SYSCLK, 32'he8);
        wt(10);
        chk("slow", 32'h3, 32'({mode == 3'h1, from_sub}));
        apb(1'b1, SCM_ADDR_FXT, 32'h0);
        wt(5);
        chk("high off", 32'h0, 32'({fxt_en, high_en}));
        apb(1'b1, SCM_ADDR_FXT, 32'h1);
        wt(210);
        chk("high on", 32'h1, 32'(high_en));
        tc = '{default: 0};
        repeat (128) begin
            @(posedge clk);
            for (int k = 0; k < 7; k++) tc[k] += (tick[k] === 1'b1);
        end
        for (int k = 0; k < 7; k++) chk("tick", 32'(128 >> k), 32'(tc[k]));
        apb(1'b1, SCM_ADDR_SYSCLK, 32'h0);
        $display("divider test done");
        // ----------------------------------------
        // watch crystal: mode frozen once it clocks the system
        // ----------------------------------------
        apb(1'b1, SCM_ADDR_WXT, 32'h1);
        wt(410);
        rd(SCM_ADDR_WXT, 32'h3, "wxt stable");
        apb(1'b1, SCM_ADDR_SYSCLK, 32'he4);
        wt(10);
        chk("wxt slow", 32'h3, 32'({mode == 3'h1, wxt_en}));
        apb(1'b1, SCM_ADDR_WXT, 32'h5);
        rd(SCM_ADDR_WXT, 32'h3, "frozen");
        apb(1'b1, SCM_ADDR_SYSCLK, 32'h0);
        wt(10);
        apb(1'b1, SCM_ADDR_WXT, 32'h5);
        rd(SCM_ADDR_WXT, 32'h7, "speedup");
        $display("watch test done");
        // ----------------------------------------
        // reset in mid-run
        // ----------------------------------------
        rst <= 1'b1;
        wt(5);
        chk("in reset", 32'h0, 32'({cpu_en, mode, irq}));
        rst <= 1'b0;
        wt(3);
        chk("after reset", 32'h7, 32'({cpu_en, slow_rc_en, frc_en}));
        rd(SCM_ADDR_SYSCLK, 32'h0, "sysclk rst");
        rd(SCM_ADDR_FRC, 32'h1, "frc rst");
        rd(SCM_ADDR_WXT, 32'h0, "wxt rst");
        $display("reset test done");
        conclude();
    end
endmodule : test_system_clock_mode_control
`default_nettype wire
